// *** npr_defines.svh ***
// Register offsets, field positions and reset values of the next page registers.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef NPR_DEFINES_SVH
`define NPR_DEFINES_SVH

// Printed register indices and their APB byte addresses
`define NPR_IDX_TX          8'h07
`define NPR_IDX_RX          8'h08
`define NPR_ADDR_TX         12'h01C
`define NPR_ADDR_RX         12'h020

// Field positions, shared by both registers
`define NPR_BIT_MORE        15
`define NPR_BIT_ACK         14
`define NPR_BIT_MSG         13
`define NPR_BIT_COMPLY      12
`define NPR_BIT_TOGGLE      11
`define NPR_CODE_MSB        10

// Reset values
`define NPR_RST_MORE        1'h1
`define NPR_RST_ACK         1'h0
`define NPR_RST_MSG         1'h1
`define NPR_RST_COMPLY      1'h0
`define NPR_RST_TOGGLE      1'h0
`define NPR_RST_CODE        11'h008
`define NPR_RST_RX          4'h0

`endif

// *** npr_pkg.sv ***
// Types shared by the next page register block.
// Assumes nothing of its surroundings.
package npr_pkg;

   // One-hot states of the APB front end
   typedef enum logic [1:0]
   {
      NPR_IDLE   = 2'b01,
      NPR_ACCESS = 2'b10
   } npr_apb_state_t;

   // Upper four bits of a received page
   typedef struct packed
   {
      logic more;
      logic ack;
      logic msg;
      logic comply;
   } npr_rx_bits_t;

endpackage : npr_pkg

// *** npr_bus_if.sv ***
// Internal register bus between the APB front end and the register file.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface npr_bus_if;
   logic [11:0] addr;
   logic        wr_stb;
   logic [31:0] wdata;
   logic [31:0] rd_data;
   logic        rd_hit;

   modport front (output addr, output wr_stb, output wdata, input rd_data, input rd_hit);
   modport regs  (input addr, input wr_stb, input wdata, output rd_data, output rd_hit);
endinterface : npr_bus_if

// *** npr_apb_front.sv ***
// APB slave front end: one wait-free access phase, registered read data.
// Assumes an APB master that holds its request until pready is seen high.
`timescale 1ns/1ps
module npr_apb_front
   import npr_pkg::*;
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   input  wire logic  psel,
   input  wire logic  penable,
   input  wire logic  pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic       pready,
   output logic       pslverr,
   output logic [31:0] prdata,
   npr_bus_if.front   bus
);

   npr_apb_state_t state;
   npr_apb_state_t next_state;
   logic           next_pready;
   logic           next_pslverr;
   logic [31:0]    next_prdata;

   // Request fields pass straight through while held by the master
   assign bus.addr   = paddr;
   assign bus.wdata  = pwdata;
   assign bus.wr_stb = (state == NPR_ACCESS) & psel & penable & pwrite & pready & ~pslverr;

   // Next state and answer, prepared during the setup cycle
   always_comb
   begin
      next_state   = state;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      next_prdata  = 32'h00000000;
      case (state)
         NPR_IDLE:
         begin
            if (psel && !penable)
            begin
               next_state   = NPR_ACCESS;
               next_pready  = 1'b1;
               next_pslverr = ~bus.rd_hit;
               next_prdata  = (!pwrite && bus.rd_hit) ? bus.rd_data : 32'h00000000;
            end
         end
         NPR_ACCESS:
         begin
            next_state = NPR_IDLE;
         end
         default:
         begin
            next_state = NPR_IDLE;
         end
      endcase
   end

   // State and answer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state   <= NPR_IDLE;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         state   <= next_state;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         prdata  <= next_prdata;
      end
   end

endmodule : npr_apb_front

// *** npr_rx_capture.sv ***
// Holds the upper four bits of the page last received from the link partner.
// Assumes rx_valid is a one-cycle pulse from the arbitration logic.
`timescale 1ns/1ps
`include "npr_defines.svh"
module npr_rx_capture
   import npr_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         rx_valid,
   input  wire logic [15:0]  rx_word,
   output npr_rx_bits_t      rx_bits
);

   npr_rx_bits_t next_rx_bits;

   // Take the partner's flags when a page arrives
   always_comb
   begin
      next_rx_bits = rx_bits;
      if (rx_valid)
      begin
         next_rx_bits.more   = rx_word[`NPR_BIT_MORE];
         next_rx_bits.ack    = rx_word[`NPR_BIT_ACK];
         next_rx_bits.msg    = rx_word[`NPR_BIT_MSG];
         next_rx_bits.comply = rx_word[`NPR_BIT_COMPLY];
      end
   end

   // Flag register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_bits <= `NPR_RST_RX;
      end
      else
      begin
         rx_bits <= next_rx_bits;
      end
   end

endmodule : npr_rx_capture

// *** npr_regs.sv ***
// Next page transmit and receive registers behind an APB slave.
// Assumes an arbitration function that reports acknowledges, exchanges and pages.
//
// Notes on behaviour
// R1 - More pages bit writable, resets to one
// R2 - Acknowledge bit read-only, set by arbitration
// R3 - Message page select writable, resets to one
// R4 - Will comply flag writable, resets to zero
// R5 - Toggle bit inverts previous exchanged toggle
// R6 - Code field writable, resets to null code
// R7 - Transmit register contents sent as page
// R8 - Partner more, ack, message bits read-only
// R9 - Partner will comply bit read-only
// R10 - Software loads page before arbitration sends
`timescale 1ns/1ps
`include "npr_defines.svh"
module npr_regs
   import npr_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic              pready,
   output logic              pslverr,
   output logic [31:0]       prdata,
   input  wire logic         ack_event,
   input  wire logic         lcw_absent,
   input  wire logic         exch_done,
   input  wire logic         exch_toggle,
   input  wire logic         rx_valid,
   input  wire logic [15:0]  rx_word,
   output logic [15:0]       tx_page,
   output logic              tx_page_updated
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   npr_bus_if     bus ();
   npr_rx_bits_t  rx_bits;

   logic          more_pages_request;
   logic          tx_ack;
   logic          message_page_select;
   logic          will_comply_flag;
   logic          tx_toggle_bit;
   logic [10:0]   tx_code;

   logic          next_more_pages_request;
   logic          next_tx_ack;
   logic          next_message_page_select;
   logic          next_will_comply_flag;
   logic          next_tx_toggle_bit;
   logic [10:0]   next_tx_code;
   logic [15:0]   next_tx_page;
   logic          next_tx_page_updated;

   logic          tx_write;
   logic [15:0]   tx_word;
   logic [15:0]   rx_view;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus front end and receive capture

   // APB protocol handling
   npr_apb_front u_front
   (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pready  (pready),
      .pslverr (pslverr),
      .prdata  (prdata),
      .bus     (bus)
   );

   // Partner page flags
   npr_rx_capture u_rx
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .rx_valid (rx_valid),
      .rx_word  (rx_word),
      .rx_bits  (rx_bits)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Register views

   // Assembled transmit page as software and the link see it
   assign tx_word = {more_pages_request,
                     tx_ack,
                     message_page_select,
                     will_comply_flag,
                     tx_toggle_bit,
                     tx_code};

   // Receive view: toggle and code read zero
   assign rx_view = {rx_bits.more,                  // see R8
                     rx_bits.ack,                   // see R8
                     rx_bits.msg,                   // see R8
                     rx_bits.comply,                // see R9
                     12'h000};

   // Write strobe for the transmit register
   assign tx_write = bus.wr_stb & (bus.addr == `NPR_ADDR_TX);

   // Read decode; unmapped addresses answer with an error
   always_comb
   begin
      bus.rd_data = 32'h00000000;
      bus.rd_hit  = 1'b0;
      case (bus.addr)
         `NPR_ADDR_TX:
         begin
            bus.rd_data = {16'h0000, tx_word};
            bus.rd_hit  = 1'b1;
         end
         `NPR_ADDR_RX:
         begin
            bus.rd_data = {16'h0000, rx_view};    // see R8
            bus.rd_hit  = 1'b1;
         end
         default:
         begin
            bus.rd_data = 32'h00000000;
            bus.rd_hit  = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software-written fields

   // Writable fields of the transmit register
   always_comb
   begin
      next_more_pages_request  = more_pages_request;
      next_message_page_select = message_page_select;
      next_will_comply_flag    = will_comply_flag;
      next_tx_code             = tx_code;
      if (tx_write)
      begin
         next_more_pages_request  = bus.wdata[`NPR_BIT_MORE];        // see R1
         next_message_page_select = bus.wdata[`NPR_BIT_MSG];         // see R3
         next_will_comply_flag    = bus.wdata[`NPR_BIT_COMPLY];      // see R4
         next_tx_code             = bus.wdata[`NPR_CODE_MSB:0];      // see R6
      end
   end

   // Writable field registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         more_pages_request  <= `NPR_RST_MORE;     // see R1
         message_page_select <= `NPR_RST_MSG;      // see R3
         will_comply_flag    <= `NPR_RST_COMPLY;   // see R4
         tx_code             <= `NPR_RST_CODE;     // see R6
      end
      else
      begin
         more_pages_request  <= next_more_pages_request;
         message_page_select <= next_message_page_select;
         will_comply_flag    <= next_will_comply_flag;
         tx_code             <= next_tx_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Arbitration-driven fields

   // Acknowledge and toggle follow the arbitration function only
   always_comb
   begin
      next_tx_ack        = tx_ack;
      next_tx_toggle_bit = tx_toggle_bit;
      if (ack_event)
      begin
         next_tx_ack = 1'b1;                        // see R2
      end
      else if (lcw_absent)
      begin
         next_tx_ack = 1'b0;                        // see R2
      end
      if (exch_done)
      begin
         next_tx_toggle_bit = ~exch_toggle;         // see R5
      end
   end

   // Arbitration field registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_ack        <= `NPR_RST_ACK;
         tx_toggle_bit <= `NPR_RST_TOGGLE;
      end
      else
      begin
         tx_ack        <= next_tx_ack;
         tx_toggle_bit <= next_tx_toggle_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Page offered to the link

   // Registered copy of the page and a pulse after each software load
   always_comb
   begin
      next_tx_page         = tx_word;               // see R7
      next_tx_page_updated = tx_write;              // see R10
   end

   // Link-side output registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_page         <= {`NPR_RST_MORE, `NPR_RST_ACK, `NPR_RST_MSG,
                             `NPR_RST_COMPLY, `NPR_RST_TOGGLE, `NPR_RST_CODE};
         tx_page_updated <= 1'b0;
      end
      else
      begin
         tx_page         <= next_tx_page;
         tx_page_updated <= next_tx_page_updated;
      end
   end

endmodule : npr_regs

// *** npr_regs_sva.sv ***
// Checker for the next page register block.
// Assumes one clock pclk and the active-low reset presetn.
`timescale 1ns/1ps
`include "npr_defines.svh"
module npr_regs_sva
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic        ack_event,
   input wire logic        lcw_absent,
   input wire logic        exch_done,
   input wire logic        exch_toggle,
   input wire logic [15:0] tx_page,
   input wire logic        tx_page_updated
);
   // Decoded bus events
   logic mapped;
   logic wr_tx;
   assign mapped = (paddr == `NPR_ADDR_TX) || (paddr == `NPR_ADDR_RX);
   assign wr_tx  = psel && penable && pwrite && pready && (paddr == `NPR_ADDR_TX);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready too long");
   property p_err; pready |-> (pslverr == !mapped); endproperty
   a_err: assert property (p_err) else $error("bad error flag");
   property p_idle; !pready |-> !pslverr && (prdata == 32'h0); endproperty
   a_idle: assert property (p_idle) else $error("outputs not idle");
   property p_upd; wr_tx |=> tx_page_updated; endproperty
   a_upd: assert property (p_upd) else $error("no update pulse");
   property p_src; tx_page_updated |-> $past(wr_tx); endproperty
   a_src: assert property (p_src) else $error("stray update pulse");
   property p_txw;
      wr_tx |-> ##2 ({tx_page[15], tx_page[13:0]} & 15'h77FF)
         == ({$past(pwdata[15], 2), $past(pwdata[13:0], 2)} & 15'h77FF);
   endproperty
   a_txw: assert property (p_txw) else $error("page not sent");
   property p_aset; ack_event |-> ##2 tx_page[14]; endproperty
   a_aset: assert property (p_aset) else $error("ack not set");
   property p_aclr; lcw_absent && !ack_event |-> ##2 !tx_page[14]; endproperty
   a_aclr: assert property (p_aclr) else $error("ack not cleared");
   property p_tog; exch_done |-> ##2 (tx_page[11] == !$past(exch_toggle, 2)); endproperty
   a_tog: assert property (p_tog) else $error("toggle wrong");
endmodule : npr_regs_sva

bind npr_regs npr_regs_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .prdata(prdata), .ack_event(ack_event),
   .lcw_absent(lcw_absent), .exch_done(exch_done), .exch_toggle(exch_toggle),
   .tx_page(tx_page), .tx_page_updated(tx_page_updated));

// *** npr_lp_model.sv ***
// Stand-in for arbitration and the link partner.
// Assumes its tasks are called just after a rising edge of pclk.
`timescale 1ns/1ps
module npr_lp_model
(
   input  wire logic   pclk,
   output logic        ack_event,
   output logic        lcw_absent,
   output logic        exch_done,
   output logic        exch_toggle,
   output logic        rx_valid,
   output logic [15:0] rx_word
);
   // Quiet at start
   initial
   begin
      {ack_event, lcw_absent, exch_done, exch_toggle, rx_valid} = 5'h00;
      rx_word = 16'h5A5A;
   end

   // Three matching bursts acknowledged
   task automatic ack;
      ack_event <= 1'b1;
      @(posedge pclk);
      ack_event <= 1'b0;
   endtask : ack

   // No link code word seen
   task automatic absent(input logic v);
      lcw_absent <= v;
   endtask : absent

   // Code word exchanged; toggle not held past it
   task automatic exch(input logic t);
      exch_done   <= 1'b1;
      exch_toggle <= t;
      @(posedge pclk);
      exch_done   <= 1'b0;
      exch_toggle <= ~t;
   endtask : exch

   // Partner page; word scrambled after its pulse
   task automatic page(input logic [15:0] w);
      rx_valid <= 1'b1;
      rx_word  <= w;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_word  <= ~w;
   endtask : page
endmodule : npr_lp_model

// *** npr_regs_tb.sv ***
// Self-checking testbench for the next page register block.
// Assumes design, checker and partner model are compiled first.
`timescale 1ns/1ps
`include "npr_defines.svh"
module npr_regs_tb;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, ack_event, lcw_absent, exch_done, exch_toggle;
   logic        rx_valid, tx_page_updated;
   logic [15:0] rx_word, tx_page;
   int          n_errors = 0;
   int          check_count = 0;

   // 10 MHz clock
   always #50 pclk = ~pclk;

   npr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .ack_event(ack_event),
      .lcw_absent(lcw_absent), .exch_done(exch_done), .exch_toggle(exch_toggle),
      .rx_valid(rx_valid), .rx_word(rx_word), .tx_page(tx_page),
      .tx_page_updated(tx_page_updated));
   npr_lp_model lp (.pclk(pclk), .ack_event(ack_event), .lcw_absent(lcw_absent),
      .exch_done(exch_done), .exch_toggle(exch_toggle), .rx_valid(rx_valid),
      .rx_word(rx_word));

   ////////////////////////////////////////
   task automatic summarize;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // One APB transfer, held until ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         n_errors++;
         summarize();
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
      chk(32'(e), 32'(xe));
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      chk(32'(e), 32'(xe));
      chk(32'(tx_page_updated), 32'(a == `NPR_ADDR_TX));
   endtask : wr

   task automatic t_reset;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`NPR_ADDR_TX, 32'h0000A008, 1'b0);
      rd(`NPR_ADDR_RX, 32'h0, 1'b0);
      chk(32'(tx_page), 32'hA008);
   endtask : t_reset

   task automatic t_write;
      wr(`NPR_ADDR_TX, 32'hFFFFFFFF, 1'b0);
      rd(`NPR_ADDR_TX, 32'h0000B7FF, 1'b0);
      chk(32'(tx_page), 32'hB7FF);
      wr(`NPR_ADDR_TX, 32'h0, 1'b0);
      rd(`NPR_ADDR_TX, 32'h0, 1'b0);
      wr(`NPR_ADDR_RX, 32'hFFFFFFFF, 1'b0);
      rd(`NPR_ADDR_RX, 32'h0, 1'b0);
      wr(12'h024, 32'hFFFFFFFF, 1'b1);
      rd(12'h024, 32'h0, 1'b1);
   endtask : t_write

   task automatic t_arb;
      lp.ack();
      rd(`NPR_ADDR_TX, 32'h00004000, 1'b0);
      lp.absent(1'b1);
      @(posedge pclk);
      rd(`NPR_ADDR_TX, 32'h0, 1'b0);
      lp.ack();
      lp.absent(1'b0);
      rd(`NPR_ADDR_TX, 32'h00004000, 1'b0);
      lp.exch(1'b0);
      rd(`NPR_ADDR_TX, 32'h00004800, 1'b0);
      lp.exch(1'b1);
      rd(`NPR_ADDR_TX, 32'h00004000, 1'b0);
      chk(32'(tx_page), 32'h4000);
   endtask : t_arb

   task automatic t_rx;
      for (int i = 0; i < 4; i++)
      begin
         lp.page((16'h1000 << i) | 16'h0ABC);
         rd(`NPR_ADDR_RX, 32'h1000 << i, 1'b0);
      end
   endtask : t_rx

   // Main sequence, with a second reset at the end
   initial
   begin
      {pclk, presetn, psel, penable, pwrite} = 5'h00;
      paddr  = 12'h000;
      pwdata = 32'h0;
      t_reset();
      t_write();
      t_arb();
      t_rx();
      t_reset();
      summarize();
   end
endmodule : npr_regs_tb
